// File: logic/accsu_core.sv
// Purpose: Accumulator with eight-level push-down stack and operand fetch
// Assumes: Sequencer and word memory run on I_MCLK; memory acks a request
// Notes:   One command at a time; O_DONE pulses when a command completes

`timescale 1ns/10ps

module accsu_core (
	input  wire logic                   I_MCLK,
	input  wire logic                   I_SYS_RST,
	input  wire logic                   I_CMD_VALID,
	input  wire accsu_pkg::accsu_cmd_s  I_CMD,
	output logic                        O_CMD_READY,
	output logic                        O_DONE,
	input  wire logic                   I_MEM_ACK,
	input  wire logic [15:0]            I_MEM_RDATA,
	output accsu_pkg::accsu_mem_s       O_MEM,
	output logic      [31:0]            O_ACC,
	output logic      [31:0]            O_STACK_TOP,
	output logic                        O_ZERO_LOAD_FLAG
);

	// ****************************************************
	// Storage
	// ****************************************************
	accsu_pkg::accsu_state_e state;
	accsu_pkg::accsu_state_e next_state;
	accsu_pkg::accsu_cmd_s   cmd_q;
	accsu_pkg::accsu_cmd_s   cur;
	accsu_pkg::accsu_mem_s   next_mem;
	logic [31:0]             acc;
	logic [31:0]             stk [accsu_pkg::STACK_DEPTH];
	logic [15:0]             lo_q;
	logic                    loaded;
	logic                    after_out;
	logic [31:0]             result;
	logic [31:0]             opnd;
	logic [15:0]             conv;

	// ****************************************************
	// Manipulation arithmetic
	// ****************************************************
	// Eight-digit packed decimal add, carry out dropped
	function automatic logic [31:0] bcd_add(input logic [31:0] a, input logic [31:0] b);
		logic [4:0]  s;
		logic        c;
		logic [31:0] r;
		c = 1'b0;
		r = 32'h0000_0000;
		s = 5'h00;
		for (int i = 0; i < accsu_pkg::BCD_DIGITS; i++) begin
			s = {1'b0, a[4*i +: 4]} + {1'b0, b[4*i +: 4]} + {4'h0, c};
			if (s > accsu_pkg::BCD_MAX) begin
				s = s + accsu_pkg::BCD_ADJ;
				c = 1'b1;
			end else begin
				c = 1'b0;
			end
			r[4*i +: 4] = s[3:0];
		end
		return r;
	endfunction

	// Combine accumulator with the second operand
	function automatic logic [31:0] manip(input logic [31:0] a, input logic [31:0] b,
			input accsu_pkg::accsu_mop_e m);
		logic [4:0]  sh;
		logic [63:0] rot;
		logic [31:0] r;
		sh  = b[4:0];
		rot = {a, a} >> sh;
		r   = a;
		unique case (m)
			accsu_pkg::MOP_AND:  r = a & b;
			accsu_pkg::MOP_OR:   r = a | b;
			accsu_pkg::MOP_XOR:  r = a ^ b;
			accsu_pkg::MOP_ADD:  r = a + b;          // Two's complement view
			accsu_pkg::MOP_SUB:  r = a - b;
			accsu_pkg::MOP_SHR:  r = a >> sh;
			accsu_pkg::MOP_ROR:  r = rot[31:0];
			accsu_pkg::MOP_ADDB: r = bcd_add(a, b);  // Packed decimal view
		endcase
		return r;
	endfunction

	// ****************************************************
	// Command decode
	// ****************************************************
	wire in_idle   = (state == accsu_pkg::ST_IDLE);
	wire fire      = I_CMD_VALID & O_CMD_READY;
	wire mem_ack   = O_MEM.req & I_MEM_ACK;
	assign cur     = in_idle ? I_CMD : cmd_q;

	wire is_write  = (cur.op == accsu_pkg::OP_OUT_WORD) | (cur.op == accsu_pkg::OP_OUT_DOUBLE);
	wire is_dbl    = (cur.op == accsu_pkg::OP_LOAD_DOUBLE_WORD) |
	                 (cur.op == accsu_pkg::OP_OUT_DOUBLE) | (cur.op == accsu_pkg::OP_MANIP);
	wire is_load   = (cur.op == accsu_pkg::OP_LOAD_WORD) |
	                 (cur.op == accsu_pkg::OP_LOAD_DOUBLE_WORD) |
	                 (cur.op == accsu_pkg::OP_LOAD_CONVERTED_ADDRESS);
	wire direct    = (cur.op == accsu_pkg::OP_POP) | (cur.op == accsu_pkg::OP_SCAN_END) |
	                 (cur.op == accsu_pkg::OP_LOAD_CONVERTED_ADDRESS) |
	                 (!is_write & (cur.src == accsu_pkg::SRC_CONST));

	// Completion points of a command
	wire read_last   = mem_ack & (((state == accsu_pkg::ST_LO) & !is_dbl) |
	                   (state == accsu_pkg::ST_HI));
	wire write_last  = mem_ack & (((state == accsu_pkg::ST_WLO) & !is_dbl) |
	                   (state == accsu_pkg::ST_WHI));
	wire commit      = (fire & direct) | read_last;
	wire load_commit = commit & is_load;
	wire scan_end    = commit & (cur.op == accsu_pkg::OP_SCAN_END);
	wire do_pop      = commit & (cur.op == accsu_pkg::OP_POP);
	wire do_push     = load_commit & loaded & !after_out;
	wire finish      = commit | write_last;

	// ****************************************************
	// Operand and result
	// ****************************************************
	// Octal digits of the address operand to binary
	accsu_oct2bin u_oct2bin (
		.i_digits (I_CMD.konst),
		.o_value  (conv)
	);

	// Constant, low word alone, or word pair low first
	always_comb begin
		if (in_idle) begin
			opnd = I_CMD.konst;
		end else if (state == accsu_pkg::ST_HI) begin
			opnd = {I_MEM_RDATA, lo_q};
		end else begin
			opnd = {accsu_pkg::HALF_ZERO, I_MEM_RDATA};
		end
	end

	// Value written into the accumulator at commit
	always_comb begin
		unique case (cur.op)
			accsu_pkg::OP_LOAD_WORD:
				result = {accsu_pkg::HALF_ZERO, opnd[15:0]};
			accsu_pkg::OP_LOAD_DOUBLE_WORD:
				result = opnd;
			accsu_pkg::OP_LOAD_CONVERTED_ADDRESS:
				result = {accsu_pkg::HALF_ZERO, conv};
			accsu_pkg::OP_MANIP:
				result = manip(acc, opnd, cur.mop);
			accsu_pkg::OP_POP:
				result = stk[0];
			accsu_pkg::OP_SCAN_END:
				result = accsu_pkg::ACC_RST;
			default:
				result = acc;
		endcase
	end

	// ****************************************************
	// Memory sequencing
	// ****************************************************
	// Pointer fetch, then one or two word reads or writes
	always_comb begin
		next_state = state;
		next_mem   = O_MEM;
		unique case (state)
			accsu_pkg::ST_IDLE: begin
				if (fire & !direct) begin
					next_mem.req   = 1'b1;
					next_mem.addr  = I_CMD.addr;
					next_mem.wdata = acc[15:0];
					next_mem.we    = is_write & (I_CMD.src != accsu_pkg::SRC_PTR);
					if (I_CMD.src == accsu_pkg::SRC_PTR) begin
						next_state = accsu_pkg::ST_PTR;
					end else if (is_write) begin
						next_state = accsu_pkg::ST_WLO;
					end else begin
						next_state = accsu_pkg::ST_LO;
					end
				end
			end
			accsu_pkg::ST_PTR: begin
				if (mem_ack) begin
					next_mem.addr = I_MEM_RDATA;
					next_mem.we   = is_write;
					next_state    = is_write ? accsu_pkg::ST_WLO : accsu_pkg::ST_LO;
				end
			end
			accsu_pkg::ST_LO: begin
				if (mem_ack & is_dbl) begin
					next_mem.addr = O_MEM.addr + accsu_pkg::ADDR_STEP;
					next_state    = accsu_pkg::ST_HI;
				end else if (mem_ack) begin
					next_mem   = accsu_pkg::MEM_RST;
					next_state = accsu_pkg::ST_IDLE;
				end
			end
			accsu_pkg::ST_HI: begin
				if (mem_ack) begin
					next_mem   = accsu_pkg::MEM_RST;
					next_state = accsu_pkg::ST_IDLE;
				end
			end
			accsu_pkg::ST_WLO: begin
				if (mem_ack & is_dbl) begin
					next_mem.addr  = O_MEM.addr + accsu_pkg::ADDR_STEP;
					next_mem.wdata = acc[31:16];
					next_state     = accsu_pkg::ST_WHI;
				end else if (mem_ack) begin
					next_mem   = accsu_pkg::MEM_RST;
					next_state = accsu_pkg::ST_IDLE;
				end
			end
			accsu_pkg::ST_WHI: begin
				if (mem_ack) begin
					next_mem   = accsu_pkg::MEM_RST;
					next_state = accsu_pkg::ST_IDLE;
				end
			end
			default: begin
				next_mem   = accsu_pkg::MEM_RST;
				next_state = accsu_pkg::ST_IDLE;
			end
		endcase
	end

	// Sequencer registers and handshake outputs
	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			state       <= accsu_pkg::ST_IDLE;
			O_MEM       <= accsu_pkg::MEM_RST;
			O_CMD_READY <= 1'b1;
			O_DONE      <= 1'b0;
		end else begin
			state       <= next_state;
			O_MEM       <= next_mem;
			O_CMD_READY <= (next_state == accsu_pkg::ST_IDLE);
			O_DONE      <= finish;
		end
	end

	// Command and low word capture
	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			cmd_q <= '0;
			lo_q  <= accsu_pkg::HALF_ZERO;
		end else begin
			if (fire) cmd_q <= I_CMD;
			if (mem_ack & (state == accsu_pkg::ST_LO)) lo_q <= I_MEM_RDATA;
		end
	end

	// ****************************************************
	// Accumulator, stack and flags
	// ****************************************************
	// Accumulator update at commit, zero flag only at load commit
	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			acc              <= accsu_pkg::ACC_RST;
			O_ZERO_LOAD_FLAG <= 1'b0;
		end else begin
			if (commit) acc <= result;
			if (load_commit) O_ZERO_LOAD_FLAG <= (result == accsu_pkg::ACC_RST);
		end
	end

	// Push moves entries down, pop moves them up
	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			for (int i = 0; i < accsu_pkg::STACK_DEPTH; i++) stk[i] <= accsu_pkg::ACC_RST;
		end else if (do_push) begin
			stk[0] <= acc;
			for (int i = 1; i < accsu_pkg::STACK_DEPTH; i++) stk[i] <= stk[i-1];
		end else if (do_pop) begin
			for (int i = 0; i < accsu_pkg::STACK_DEPTH - 1; i++) stk[i] <= stk[i+1];
			stk[accsu_pkg::STACK_DEPTH-1] <= accsu_pkg::ACC_RST;
		end
	end

	// Scan position: first load seen, output since last load
	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			loaded    <= 1'b0;
			after_out <= 1'b0;
		end else if (scan_end) begin
			loaded    <= 1'b0;
			after_out <= 1'b0;
		end else if (load_commit) begin
			loaded    <= 1'b1;
			after_out <= 1'b0;
		end else if (write_last) begin
			after_out <= 1'b1;
		end
	end

	assign O_ACC       = acc;
	assign O_STACK_TOP = stk[0];

	// ****************************************************
	// Checks
	// ****************************************************
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_SYS_RST);

	sequence s_dbl_write_lo;
		(state == accsu_pkg::ST_WLO) && mem_ack && is_dbl;
	endsequence

	sequence s_hi_word_out;
		(state == accsu_pkg::ST_WHI) && O_MEM.we && (O_MEM.wdata == acc[31:16]);
	endsequence

	chk_scan_clear_acc: assert property (scan_end |=> (O_ACC == 32'h0000_0000) && !loaded)
		else $error("accumulator not cleared at scan end");
	chk_word_upper_zero: assert property (
		load_commit && (cur.op == accsu_pkg::OP_LOAD_WORD) |=>
		(O_ACC[31:16] == 16'h0000) && (O_ACC[15:0] == $past(opnd[15:0])))
		else $error("word load left upper half set");
	chk_first_load_nopush: assert property (
		load_commit && !loaded |=> (O_STACK_TOP == $past(O_STACK_TOP)))
		else $error("first load of scan pushed the stack");
	chk_out_then_load: assert property (
		load_commit && after_out |=> (stk[1] == $past(stk[1])) && (O_STACK_TOP == $past(stk[0])))
		else $error("load after output pushed the stack");
	chk_push_shift_down: assert property (
		load_commit && loaded && !after_out |=>
		(O_STACK_TOP == $past(acc)) && (stk[1] == $past(stk[0])))
		else $error("push did not shift the stack down");
	chk_full_drop: assert property (do_push |=> stk[7] == $past(stk[6]))
		else $error("bottom entry not replaced on push");
	chk_pop_moves_up: assert property (
		do_pop |=> (O_ACC == $past(stk[0])) && (O_STACK_TOP == $past(stk[1])))
		else $error("pop did not move the stack up");
	chk_pop_zero_fill: assert property (do_pop |=> stk[7] == 32'h0000_0000)
		else $error("bottom entry not zero after pop");
	chk_zero_flag_load: assert property (
		load_commit |=> O_ZERO_LOAD_FLAG == (O_ACC == 32'h0000_0000))
		else $error("zero flag does not match loaded value");
	chk_double_adjacent: assert property (
		s_dbl_write_lo |=> (O_MEM.addr == $past(O_MEM.addr) + 16'h0001) ##0 s_hi_word_out)
		else $error("double output words not adjacent");
	chk_ready_done: assert property (finish |=> O_DONE && O_CMD_READY)
		else $error("completion not reported");

endmodule

// File: logic/accsu_oct2bin.sv
// Purpose: Turns a nibble-per-digit octal address into its binary value
// Assumes: Each nibble holds one octal digit, least significant digit lowest
// Notes:   Only the low three bits of a nibble count; six digits give 16 bits

`timescale 1ns/10ps

module accsu_oct2bin (
	input  wire logic [31:0] i_digits,
	output logic      [15:0] o_value
);

	// ****************************************************
	// Digit packing
	// ****************************************************
	// Each octal digit is three binary bits
	always_comb begin
		o_value = 16'h0000;
		for (int g = 0; g < accsu_pkg::OCT_FULL; g++) begin
			o_value[accsu_pkg::OCT_W*g +: accsu_pkg::OCT_W] =
				i_digits[accsu_pkg::DIGIT_W*g +: accsu_pkg::OCT_W];
		end
		o_value[15] = i_digits[accsu_pkg::OCT_TOP_BIT]; // Top digit gives one bit
	end

endmodule

// File: logic/accsu_pkg.sv
// Purpose: Shared constants and types for the accumulator stack unit
// Assumes: One clock domain, sequencer and word memory on that clock
// Notes:   Packed structs carry the command and the memory request

package accsu_pkg;

	// ****************************************************
	// Widths, depths and counts
	// ****************************************************
	localparam int              ACC_W       = 32;
	localparam int              WORD_W      = 16;
	localparam int              STACK_DEPTH = 8;
	localparam int              BCD_DIGITS  = 8;
	localparam int              DIGIT_W     = 4;
	localparam int              OCT_W       = 3;
	localparam int              OCT_FULL    = 5;
	localparam int              OCT_TOP_BIT = 20;
	localparam logic [15:0]     ADDR_STEP   = 16'h0001;
	localparam logic [15:0]     HALF_ZERO   = 16'h0000;
	localparam logic [4:0]      BCD_MAX     = 5'h09;
	localparam logic [4:0]      BCD_ADJ     = 5'h06;

	// ****************************************************
	// Values after reset
	// ****************************************************
	localparam logic [31:0]     ACC_RST     = 32'h0000_0000;

	// ****************************************************
	// Commands, sources, manipulations and states
	// ****************************************************
	typedef enum logic [3:0] {
		OP_LOAD_WORD              = 4'h0,
		OP_LOAD_DOUBLE_WORD       = 4'h1,
		OP_LOAD_CONVERTED_ADDRESS = 4'h2,
		OP_OUT_WORD               = 4'h3,
		OP_OUT_DOUBLE             = 4'h4,
		OP_POP                    = 4'h5,
		OP_MANIP                  = 4'h6,
		OP_SCAN_END               = 4'h7
	} accsu_op_e;

	typedef enum logic [1:0] {
		SRC_MEM   = 2'h0,
		SRC_PTR   = 2'h1,
		SRC_CONST = 2'h2
	} accsu_src_e;

	typedef enum logic [2:0] {
		MOP_AND  = 3'h0,
		MOP_OR   = 3'h1,
		MOP_XOR  = 3'h2,
		MOP_ADD  = 3'h3,
		MOP_SUB  = 3'h4,
		MOP_SHR  = 3'h5,
		MOP_ROR  = 3'h6,
		MOP_ADDB = 3'h7
	} accsu_mop_e;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_PTR  = 6'h02,
		ST_LO   = 6'h04,
		ST_HI   = 6'h08,
		ST_WLO  = 6'h10,
		ST_WHI  = 6'h20
	} accsu_state_e;

	typedef struct packed {
		accsu_op_e   op;
		accsu_src_e  src;
		accsu_mop_e  mop;
		logic [15:0] addr;
		logic [31:0] konst;
	} accsu_cmd_s;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} accsu_mem_s;

	localparam accsu_mem_s      MEM_RST     = '0;

endpackage

// File: test/accsu_mem_model.sv
// Purpose: Behavioural 16-bit word memory on the far side of the unit
// Assumes: Same clock as the unit; a request is held until acknowledged
// Notes:   Slow mode stalls each request two cycles; idle read data is the inverse of the last read

`timescale 1ns/10ps

module accsu_mem_model (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	input  wire accsu_pkg::accsu_mem_s i_mem,
	input  wire logic                  i_slow,
	output logic                       o_ack,
	output logic      [15:0]           o_rdata
);
	// ****************************************************
	// Storage and handshake
	// ****************************************************
	logic [15:0] mem [1024];
	logic [1:0]  stall;
	logic [15:0] last;

	// Acknowledge at once, or after two stalled cycles
	assign o_ack   = i_mem.req && (!i_slow || stall == 2'h2);
	// Data only while a read is acknowledged, inverse of last read otherwise
	assign o_rdata = (o_ack && !i_mem.we) ? mem[i_mem.addr[9:0]] : ~last;

	// Stall count, write port and last read value
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			stall <= 2'h0;
			last  <= 16'h0000;
		end else begin
			stall <= (o_ack || !i_mem.req) ? 2'h0 : stall + 2'h1;
			if (o_ack && i_mem.we)
				mem[i_mem.addr[9:0]] <= i_mem.wdata;
			if (o_ack && !i_mem.we)
				last <= o_rdata;
		end
	end
endmodule

// File: test/testbench.sv
// Purpose: Self-checking bench for the accumulator stack unit
// Assumes: Bench acts as sequencer; memory model answers on the far side
// Notes:   Driver notes expected results; a monitor compares on each done

`timescale 1ns/10ps

module testbench;
	// ****************************************************
	// Signals, reference state and shortcuts
	// ****************************************************
	localparam accsu_pkg::accsu_op_e  lw = accsu_pkg::OP_LOAD_WORD;
	localparam accsu_pkg::accsu_op_e  ldw = accsu_pkg::OP_LOAD_DOUBLE_WORD;
	localparam accsu_pkg::accsu_op_e  lca = accsu_pkg::OP_LOAD_CONVERTED_ADDRESS;
	localparam accsu_pkg::accsu_op_e  ow = accsu_pkg::OP_OUT_WORD;
	localparam accsu_pkg::accsu_op_e  od = accsu_pkg::OP_OUT_DOUBLE;
	localparam accsu_pkg::accsu_op_e  pp = accsu_pkg::OP_POP;
	localparam accsu_pkg::accsu_op_e  mn = accsu_pkg::OP_MANIP;
	localparam accsu_pkg::accsu_op_e  se = accsu_pkg::OP_SCAN_END;
	localparam accsu_pkg::accsu_src_e sm = accsu_pkg::SRC_MEM;
	localparam accsu_pkg::accsu_src_e sp = accsu_pkg::SRC_PTR;
	localparam accsu_pkg::accsu_src_e sk = accsu_pkg::SRC_CONST;
	localparam accsu_pkg::accsu_mop_e an = accsu_pkg::MOP_AND;
	logic                  I_MCLK = 1'b0;
	logic                  I_SYS_RST = 1'b1;
	logic                  I_CMD_VALID = 1'b0;
	logic                  slow = 1'b0;
	accsu_pkg::accsu_cmd_s I_CMD = '0;
	logic                  O_CMD_READY, O_DONE, I_MEM_ACK, O_ZERO_LOAD_FLAG;
	logic [15:0]           I_MEM_RDATA;
	accsu_pkg::accsu_mem_s O_MEM;
	logic [31:0]           O_ACC, O_STACK_TOP, acc, r;
	logic [31:0]           st [8];
	logic [15:0]           sh [1024];
	logic                  flag, had_load, outd;
	logic [64:0]           notes [$];
	logic [64:0]           e;
	int                    fails = 0, checked = 0, cycles = 0, seed = 55434;

	accsu_core DUT (.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_CMD_VALID(I_CMD_VALID),
		.I_CMD(I_CMD), .O_CMD_READY(O_CMD_READY), .O_DONE(O_DONE), .I_MEM_ACK(I_MEM_ACK),
		.I_MEM_RDATA(I_MEM_RDATA), .O_MEM(O_MEM), .O_ACC(O_ACC), .O_STACK_TOP(O_STACK_TOP),
		.O_ZERO_LOAD_FLAG(O_ZERO_LOAD_FLAG));
	accsu_mem_model MEM (.i_clk(I_MCLK), .i_rst(I_SYS_RST), .i_mem(O_MEM), .i_slow(slow),
		.o_ack(I_MEM_ACK), .o_rdata(I_MEM_RDATA));

	// Clock, 50 ns period
	initial begin
		forever #25 I_MCLK = ~I_MCLK;
	end

	// ****************************************************
	// Reference helpers and driver
	// ****************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			fails++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Digit-wise decimal add, final carry dropped
	function automatic logic [31:0] bcd(input logic [31:0] a, input logic [31:0] b);
		logic [4:0]  s;
		logic        c;
		logic [31:0] q;
		c = 1'b0;
		q = '0;
		for (int i = 0; i < 8; i++) begin
			s = {1'b0, a[i*4+:4]} + {1'b0, b[i*4+:4]} + {4'h0, c};
			c = (s > 5'h09);
			q[i*4+:4] = c ? 4'(s - 5'h0a) : s[3:0];
		end
		return q;
	endfunction

	function automatic logic [31:0] fmop(input logic [2:0] m, input logic [31:0] a,
		input logic [31:0] b);
		case (m)
			3'h0: return a & b;
			3'h1: return a | b;
			3'h2: return a ^ b;
			3'h3: return a + b;
			3'h4: return a - b;
			3'h5: return a >> b[4:0];
			3'h6: return (a >> b[4:0]) | (a << (6'h20 - {1'b0, b[4:0]}));
			default: return bcd(a, b);
		endcase
	endfunction

	task poke(input logic [9:0] a, input logic [15:0] v);
		sh[a] = v;
		MEM.mem[a] = v;
	endtask

	// Load into reference: push unless first load or after an output
	task load(input logic [31:0] v);
		if (had_load && !outd) begin
			for (int i = 7; i > 0; i--)
				st[i] = st[i-1];
			st[0] = acc;
		end
		acc = v;
		flag = (v == 32'h0000_0000);
		had_load = 1'b1;
		outd = 1'b0;
	endtask

	// Offer one command at a falling edge; memory commands wait for done
	task issue(input accsu_pkg::accsu_op_e op, input accsu_pkg::accsu_src_e src,
		input logic [2:0] m, input logic [15:0] addr, input logic [31:0] k);
		logic [9:0]  b;
		logic [31:0] d;
		logic        mc;
		int          n;
		n = 0;
		while (O_CMD_READY !== 1'b1 && n < 100) begin
			@(negedge I_MCLK);
			n++;
		end
		if (n == 100) begin
			fails++;
			$display("mismatch at %0t: ready never returned", $time);
		end
		b = (src == sp) ? sh[addr[9:0]][9:0] : addr[9:0];
		d = (src == sk) ? k : {sh[b+10'h1], sh[b]};
		mc = !(op inside {pp, se, lca}) && (src != sk || op inside {ow, od});
		case (op)
			lw: load({16'h0000, (src == sk) ? k[15:0] : sh[b]});
			ldw: load(d);
			lca: load({16'h0000, k[20], k[18:16], k[14:12], k[10:8], k[6:4], k[2:0]});
			ow: begin
				sh[b] = acc[15:0];
				outd = 1'b1;
			end
			od: begin
				sh[b] = acc[15:0];
				sh[b+10'h1] = acc[31:16];
				outd = 1'b1;
			end
			pp: begin
				acc = st[0];
				for (int i = 0; i < 7; i++)
					st[i] = st[i+1];
				st[7] = '0;
			end
			mn: acc = fmop(m, acc, d);
			default: begin
				acc = '0;
				had_load = 1'b0;
				outd = 1'b0;
			end
		endcase
		notes.push_back({acc, st[0], flag});
		I_CMD = '{op, src, accsu_pkg::accsu_mop_e'(m), addr, k};
		I_CMD_VALID = 1'b1;
		slow = 1'($random(seed));
		@(negedge I_MCLK);
		if (mc) begin
			I_CMD_VALID = 1'b0;
			n = 0;
			while (O_DONE !== 1'b1 && n < 100) begin
				@(negedge I_MCLK);
				n++;
			end
			if (n == 100) begin
				fails++;
				$display("mismatch at %0t: done never came", $time);
			end
		end
	endtask

	task idle(input string s);
		I_CMD_VALID = 1'b0;
		@(negedge I_MCLK);
		$display("test %s finished", s);
	endtask

	// ****************************************************
	// Monitor, timeout and main sequence
	// ****************************************************
	always @(negedge I_MCLK) begin
		if (O_DONE === 1'b1) begin
			if (notes.size() == 0) begin
				fails++;
				$display("mismatch at %0t: unexpected done", $time);
			end else begin
				e = notes.pop_front();
				check(O_ACC, e[64:33]);
				check(O_STACK_TOP, e[32:1]);
				check({31'h0, O_ZERO_LOAD_FLAG}, {31'h0, e[0]});
			end
		end
	end

	always @(posedge I_MCLK) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			$display("mismatch at %0t: timeout", $time);
			end_of_test();
		end
	end

	initial begin
		acc = '0;
		flag = 1'b0;
		had_load = 1'b0;
		outd = 1'b0;
		for (int i = 0; i < 8; i++)
			st[i] = '0;
		for (int i = 0; i < 1024; i++)
			poke(10'(i), (i < 16) ? 16'(16 + $unsigned($random(seed)) % 900) : 16'($random(seed)));
		repeat (2) @(posedge I_MCLK);
		@(negedge I_MCLK);
		I_SYS_RST = 1'b0;
		check(O_ACC, 32'h0000_0000);
		check({31'h0, O_CMD_READY}, 32'h0000_0001);
		// Every load source, then outputs and a pointer made by address load
		issue(lw, sk, 0, 16'h0, 32'hffff_0000);
		issue(lw, sm, 0, 16'h40, 0);
		issue(lw, sp, 0, 16'h3, 0);
		issue(ldw, sk, 0, 16'h0, $random(seed));
		issue(ldw, sm, 0, 16'h50, 0);
		issue(ldw, sp, 0, 16'h4, 0);
		issue(lca, sk, 0, 16'h0, 32'h0004_0400);
		idle("loads");
		check(O_ACC, 32'h0000_4100);
		issue(ow, sm, 0, 16'h100, 0);
		issue(od, sm, 0, 16'h102, 0);
		issue(od, sp, 0, 16'h5, 0);
		issue(lca, sk, 0, 16'h0, 32'h0000_1000);
		issue(ow, sk, 0, 16'h6, 0);
		issue(lw, sp, 0, 16'h6, 0);
		idle("outputs");
		check(O_ACC, {16'h0000, sh[10'h200]});
		for (int a = 256; a < 260; a++)
			check({16'h0, MEM.mem[a]}, {16'h0, sh[a]});
		// Every manipulation, constant and double-word memory operand
		for (int i = 0; i < 16; i++) begin
			r = $random(seed) & 32'h7777_7777;
			poke(10'h60, r[15:0]);
			poke(10'h61, r[31:16]);
			issue(se, sk, 0, 16'h0, 0);
			issue(ldw, sk, 0, 16'h0, $random(seed) & 32'h7777_7777);
			issue(mn, i[0] ? sm : sk, 3'(i >> 1), 16'h60, r);
		end
		issue(od, sm, 0, 16'h70, 0);
		idle("manip");
		// Overfill the stack, then pop past its depth
		issue(se, sk, 0, 16'h0, 0);
		for (int i = 1; i <= 10; i++)
			issue(lw, sk, 0, 16'h0, i);
		for (int i = 0; i < 10; i++)
			issue(pp, sk, 0, 16'h0, 0);
		idle("stack");
		check(O_ACC, 32'h0000_0000);
		// Scan end clears, next load writes only
		issue(lw, sk, 0, 16'h0, 32'h55);
		issue(se, sk, 0, 16'h0, 0);
		idle("scan");
		check(O_ACC, 32'h0000_0000);
		issue(lw, sk, 0, 16'h0, 32'h77);
		// Random command mix
		for (int i = 0; i < 80; i++) begin
			r = $unsigned($random(seed)) % 3;
			issue(accsu_pkg::accsu_op_e'(4'($unsigned($random(seed)) % 8)),
				accsu_pkg::accsu_src_e'(r[1:0]), 3'($unsigned($random(seed)) % 7),
				(r == 1) ? 16'($unsigned($random(seed)) % 16) : 16'(16 + $unsigned($random(seed)) % 900),
				$random(seed));
		end
		idle("random");
		check(32'(notes.size()), 32'h0000_0000);
		end_of_test();
	end
endmodule
